/* File: rtl/scsu_pkg.sv */
// Constants shared by the system clock select unit
package scsu_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CLOCK_CONTROL = 8'h00;
  localparam logic [7:0] OFS_CLOCK_TUNING = 8'h04;
  localparam logic [7:0] OFS_TIMER1_CONTROL = 8'h08;
  localparam logic [7:0] OFS_CLOCK_CONFIG = 8'h0C;
  // Clock control register fields
  localparam int IDLE_BIT = 7;
  localparam int IFS_LSB = 4;
  localparam int PSD_BIT = 3;
  localparam int ONE_BIT = 2;
  localparam int CSS_LSB = 0;
  // Tuning register fields
  localparam int LFS_BIT = 7;
  localparam int PLLEN_BIT = 6;
  localparam int TUNE_LSB = 0;
  // Timer-1 control fields
  localparam int SCA_BIT = 6;
  localparam int SOE_BIT = 3;
  // Configuration register fields
  localparam int OMC_LSB = 0;
  localparam int PPS_LSB = 4;
  localparam int CPD_LSB = 8;
  // Clock source select encodings
  localparam logic [1:0] CSS_PRIMARY = 2'h0;
  localparam logic [1:0] CSS_SECONDARY = 2'h1;
  localparam logic [1:0] CSS_RESERVED = 2'h2;
  localparam logic [1:0] CSS_INTERNAL = 2'h3;
  // Oscillator mode encodings
  localparam logic [2:0] OMC_INT = 3'h0;
  localparam logic [2:0] OMC_INT_ALT = 3'h1;
  localparam logic [2:0] OMC_HS = 3'h4;
  localparam logic [2:0] OMC_CRYSTAL_PLL = 3'h5;
  localparam logic [2:0] OMC_EC = 3'h6;
  localparam logic [2:0] OMC_EXT_CLOCK_PLL = 3'h7;
  // Values after reset
  localparam logic [2:0] IFS_RESET = 3'h6;
  localparam logic [2:0] OMC_RESET = OMC_HS;
  localparam logic [2:0] PPS_RESET = 3'h7;
  localparam logic [1:0] CPD_RESET = 2'h3;
  // Cycle counts, in ticks of the source concerned
  localparam logic [10:0] STARTUP_TICKS = 11'h400;
  localparam logic [1:0] OLD_SRC_TICKS = 2'h2;
  localparam logic [1:0] NEW_SRC_TICKS = 2'h3;
  localparam logic [8:0] PLL_HALF_RATIO = 9'h002;
  localparam logic [8:0] USB_LS_RATIO = 9'h004;
  typedef enum logic [2:0] {
    SW_RUN = 3'b001,
    SW_OLD = 3'b010,
    SW_NEW = 3'b100
  } scsu_sw_state_t;
endpackage : scsu_pkg

/* File: rtl/scsu_div.sv */
// Tick divider: one output tick for every ratio input ticks
`timescale 1ns/1ns
`default_nettype none
module scsu_div (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Ticks
  input wire logic tick_in,
  input wire logic [8:0] ratio,
  output logic tick_out
);
  logic [8:0] count;
  logic [8:0] next_count;
  logic wrap;

  // A count left beyond a freshly lowered ratio wraps at once
  assign wrap = (count >= ratio - 9'h001);
  assign tick_out = tick_in & wrap;

  always_comb
  begin
    next_count = count;
    if (tick_in)
      next_count = wrap ? 9'h000 : count + 9'h001;
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
      count <= 9'h000;
    else
      count <= next_count;
  end
endmodule : scsu_div
`default_nettype wire

/* File: rtl/scsu_top.sv */
// System clock select unit: source selection, dividers and status
//
// Decided for this implementation: the address map and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
module scsu_top (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Oscillator ticks
  input wire logic PRI_OSC_TICK,
  input wire logic SEC_OSC_TICK,
  input wire logic FAST_OSC_TICK,
  input wire logic SLOW_OSC_TICK,
  input wire logic PLL_OUT_TICK,
  // Sleep control
  input wire logic SLEEP_REQ,
  input wire logic WAKE_REQ,
  // Clock outputs
  output logic DEV_CLK_TICK,
  output logic PLL_REF_TICK,
  output logic USB_FS_TICK,
  output logic USB_LS_TICK,
  output logic WDT_TICK,
  output logic FSCM_TICK,
  // Power state
  output logic SLEEP_MODE,
  output logic IDLE_MODE
);
  // Register state
  logic idle_on_sleep;
  logic [2:0] internal_freq_sel;
  logic [1:0] clock_source_sel;
  logic low_freq_source_sel;
  logic pll_enable;
  logic [5:0] tune;
  logic secondary_osc_enable;
  logic [2:0] osc_mode_cfg;
  logic [2:0] pll_prescale_sel;
  logic [1:0] cpu_clock_div;
  logic next_idle_on_sleep;
  logic [2:0] next_internal_freq_sel;
  logic [1:0] next_clock_source_sel;
  logic next_low_freq_source_sel;
  logic next_pll_enable;
  logic [5:0] next_tune;
  logic next_secondary_osc_enable;
  logic [2:0] next_osc_mode_cfg;
  logic [2:0] next_pll_prescale_sel;
  logic [1:0] next_cpu_clock_div;
  // Bus state
  logic ack;
  logic [31:0] rdata;
  logic next_ack;
  logic [31:0] next_rdata;
  logic wr_commit;
  // Start-up timer
  logic [10:0] startup_cnt;
  logic [10:0] next_startup_cnt;
  logic startup_done;
  // Switch state
  scsu_pkg::scsu_sw_state_t sw_state;
  scsu_pkg::scsu_sw_state_t next_sw_state;
  logic [1:0] active_sel;
  logic [1:0] target_sel;
  logic [1:0] next_active_sel;
  logic [1:0] next_target_sel;
  logic [1:0] sw_cnt;
  logic [1:0] next_sw_cnt;
  logic [1:0] want_sel;
  // Power state
  logic sleep_mode;
  logic idle_mode;
  logic next_sleep_mode;
  logic next_idle_mode;
  // Clock paths
  logic [8:0] prescale_ratio;
  logic [8:0] cpu_ratio;
  logic [8:0] post_ratio;
  logic mode_pll;
  logic mode_internal;
  logic pll_active;
  logic pll_ref;
  logic pll_half;
  logic cpu_in;
  logic cpu_tick;
  logic post_tick;
  logic int_tick;
  logic pri_tick;
  logic usb_ls;
  logic old_tick;
  logic new_tick;
  logic dev_tick;
  logic status_psd;
  logic status_sca;

  assign mode_pll = (osc_mode_cfg == scsu_pkg::OMC_CRYSTAL_PLL) ||
                    (osc_mode_cfg == scsu_pkg::OMC_EXT_CLOCK_PLL);
  assign mode_internal = (osc_mode_cfg == scsu_pkg::OMC_INT) || (osc_mode_cfg == scsu_pkg::OMC_INT_ALT);
  assign pll_active = mode_pll & pll_enable;

  // Divider ratios
  always_comb
  begin
    case (pll_prescale_sel)
      3'h0: prescale_ratio = 9'h00C;
      3'h1: prescale_ratio = 9'h00A;
      3'h2: prescale_ratio = 9'h006;
      3'h3: prescale_ratio = 9'h005;
      3'h4: prescale_ratio = 9'h004;
      3'h5: prescale_ratio = 9'h003;
      3'h6: prescale_ratio = 9'h002;
      default: prescale_ratio = 9'h001;
    endcase
    case (cpu_clock_div)
      2'h3: cpu_ratio = 9'h001;
      2'h2: cpu_ratio = 9'h002;
      2'h1: cpu_ratio = 9'h003;
      default: cpu_ratio = 9'h006;
    endcase
    case (internal_freq_sel)
      3'h7: post_ratio = 9'h001;
      3'h6: post_ratio = 9'h002;
      3'h5: post_ratio = 9'h004;
      3'h4: post_ratio = 9'h008;
      3'h3: post_ratio = 9'h010;
      3'h2: post_ratio = 9'h020;
      3'h1: post_ratio = 9'h040;
      default: post_ratio = 9'h100;
    endcase
  end

  // PLL reference from the primary oscillator
  scsu_div u_prescale (
    .CLK(CLK),
    .RESET(RESET),
    .tick_in(PRI_OSC_TICK),
    .ratio(prescale_ratio),
    .tick_out(pll_ref)
  );

  // The PLL output is halved to the 48 MHz full-speed rate
  scsu_div u_pll_half (
    .CLK(CLK),
    .RESET(RESET),
    .tick_in(PLL_OUT_TICK),
    .ratio(scsu_pkg::PLL_HALF_RATIO),
    .tick_out(pll_half)
  );

  assign cpu_in = pll_active ? pll_half : PRI_OSC_TICK;

  scsu_div u_cpu_div (
    .CLK(CLK),
    .RESET(RESET),
    .tick_in(cpu_in),
    .ratio(cpu_ratio),
    .tick_out(cpu_tick)
  );

  // Low-speed USB runs at a quarter of the CPU clock
  scsu_div u_usb_ls (
    .CLK(CLK),
    .RESET(RESET),
    .tick_in(cpu_tick),
    .ratio(scsu_pkg::USB_LS_RATIO),
    .tick_out(usb_ls)
  );

  // Postscaler ratio follows the frequency select at once
  scsu_div u_postscale (
    .CLK(CLK),
    .RESET(RESET),
    .tick_in(FAST_OSC_TICK),
    .ratio(post_ratio),
    .tick_out(post_tick)
  );

  // Slow oscillator only at code 000 with the low-frequency bit clear
  assign int_tick = ((internal_freq_sel == 3'h0) && !low_freq_source_sel) ? SLOW_OSC_TICK : post_tick;
  assign pri_tick = mode_internal ? int_tick : cpu_tick;

  // Reserved requests keep the running source
  assign want_sel = (clock_source_sel == scsu_pkg::CSS_RESERVED) ? target_sel : clock_source_sel;

  always_comb
  begin
    case (active_sel)
      scsu_pkg::CSS_SECONDARY: old_tick = SEC_OSC_TICK;
      scsu_pkg::CSS_INTERNAL: old_tick = int_tick;
      default: old_tick = pri_tick;
    endcase
    case (target_sel)
      scsu_pkg::CSS_SECONDARY: new_tick = SEC_OSC_TICK;
      scsu_pkg::CSS_INTERNAL: new_tick = int_tick;
      default: new_tick = pri_tick;
    endcase
  end

  // Register file and bus
  assign wr_commit = WB_CYC_I & WB_STB_I & WB_WE_I & ack;

  always_comb
  begin
    next_idle_on_sleep = idle_on_sleep;
    next_internal_freq_sel = internal_freq_sel;
    next_clock_source_sel = clock_source_sel;
    next_low_freq_source_sel = low_freq_source_sel;
    next_pll_enable = pll_enable;
    next_tune = tune;
    next_secondary_osc_enable = secondary_osc_enable;
    next_osc_mode_cfg = osc_mode_cfg;
    next_pll_prescale_sel = pll_prescale_sel;
    next_cpu_clock_div = cpu_clock_div;
    if (wr_commit && WB_SEL_I[0])
    begin
      case (WB_ADR_I)
        scsu_pkg::OFS_CLOCK_CONTROL:
        begin
          next_idle_on_sleep = WB_DAT_I[scsu_pkg::IDLE_BIT];
          next_internal_freq_sel = WB_DAT_I[scsu_pkg::IFS_LSB +: 3];
          // Timer-1 source only with its oscillator enabled
          if (WB_DAT_I[scsu_pkg::CSS_LSB +: 2] != scsu_pkg::CSS_SECONDARY || secondary_osc_enable)
            next_clock_source_sel = WB_DAT_I[scsu_pkg::CSS_LSB +: 2];
        end
        scsu_pkg::OFS_CLOCK_TUNING:
        begin
          next_low_freq_source_sel = WB_DAT_I[scsu_pkg::LFS_BIT];
          next_pll_enable = WB_DAT_I[scsu_pkg::PLLEN_BIT];
          next_tune = WB_DAT_I[scsu_pkg::TUNE_LSB +: 6];
        end
        scsu_pkg::OFS_TIMER1_CONTROL: next_secondary_osc_enable = WB_DAT_I[scsu_pkg::SOE_BIT];
        scsu_pkg::OFS_CLOCK_CONFIG:
        begin
          next_osc_mode_cfg = WB_DAT_I[scsu_pkg::OMC_LSB +: 3];
          next_pll_prescale_sel = WB_DAT_I[scsu_pkg::PPS_LSB +: 3];
        end
        default: ;
      endcase
    end
    if (wr_commit && WB_SEL_I[1] && WB_ADR_I == scsu_pkg::OFS_CLOCK_CONFIG)
      next_cpu_clock_div = WB_DAT_I[scsu_pkg::CPD_LSB +: 2];
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      idle_on_sleep <= 1'b0;
      internal_freq_sel <= scsu_pkg::IFS_RESET;
      clock_source_sel <= scsu_pkg::CSS_PRIMARY;
      low_freq_source_sel <= 1'b0;
      pll_enable <= 1'b0;
      tune <= 6'h00;
      secondary_osc_enable <= 1'b0;
      osc_mode_cfg <= scsu_pkg::OMC_RESET;
      pll_prescale_sel <= scsu_pkg::PPS_RESET;
      cpu_clock_div <= scsu_pkg::CPD_RESET;
    end
    else
    begin
      idle_on_sleep <= next_idle_on_sleep;
      internal_freq_sel <= next_internal_freq_sel;
      clock_source_sel <= next_clock_source_sel;
      low_freq_source_sel <= next_low_freq_source_sel;
      pll_enable <= next_pll_enable;
      tune <= next_tune;
      secondary_osc_enable <= next_secondary_osc_enable;
      osc_mode_cfg <= next_osc_mode_cfg;
      pll_prescale_sel <= next_pll_prescale_sel;
      cpu_clock_div <= next_cpu_clock_div;
    end
  end

  // Status bits: only the running source reports, so never both
  assign status_psd = startup_done && active_sel == scsu_pkg::CSS_PRIMARY && sw_state == scsu_pkg::SW_RUN;
  assign status_sca = active_sel == scsu_pkg::CSS_SECONDARY && sw_state == scsu_pkg::SW_RUN;

  always_comb
  begin
    next_ack = WB_CYC_I & WB_STB_I & ~ack;
    next_rdata = 32'h0000_0000;
    case (WB_ADR_I)
      scsu_pkg::OFS_CLOCK_CONTROL:
      begin
        next_rdata[scsu_pkg::IDLE_BIT] = idle_on_sleep;
        next_rdata[scsu_pkg::IFS_LSB +: 3] = internal_freq_sel;
        next_rdata[scsu_pkg::PSD_BIT] = status_psd;
        next_rdata[scsu_pkg::ONE_BIT] = 1'b1;
        next_rdata[scsu_pkg::CSS_LSB +: 2] = clock_source_sel;
      end
      scsu_pkg::OFS_CLOCK_TUNING:
      begin
        next_rdata[scsu_pkg::LFS_BIT] = low_freq_source_sel;
        next_rdata[scsu_pkg::PLLEN_BIT] = pll_enable;
        next_rdata[scsu_pkg::TUNE_LSB +: 6] = tune;
      end
      scsu_pkg::OFS_TIMER1_CONTROL:
      begin
        next_rdata[scsu_pkg::SCA_BIT] = status_sca;
        next_rdata[scsu_pkg::SOE_BIT] = secondary_osc_enable;
      end
      scsu_pkg::OFS_CLOCK_CONFIG:
      begin
        next_rdata[scsu_pkg::OMC_LSB +: 3] = osc_mode_cfg;
        next_rdata[scsu_pkg::PPS_LSB +: 3] = pll_prescale_sel;
        next_rdata[scsu_pkg::CPD_LSB +: 2] = cpu_clock_div;
      end
      default: ;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
    end
    else
    begin
      ack <= next_ack;
      rdata <= next_rdata;
    end
  end

  assign WB_ACK_O = ack;
  assign WB_DAT_O = rdata;

  // Start-up timer counts primary oscillator ticks once after reset
  assign startup_done = (startup_cnt == scsu_pkg::STARTUP_TICKS) || mode_internal;

  always_comb
  begin
    next_startup_cnt = startup_cnt;
    if (PRI_OSC_TICK && startup_cnt != scsu_pkg::STARTUP_TICKS)
      next_startup_cnt = startup_cnt + 11'h001;
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
      startup_cnt <= 11'h000;
    else
      startup_cnt <= next_startup_cnt;
  end

  // Glitch-free switch: drain old ticks, then wait for the new source
  always_comb
  begin
    next_sw_state = sw_state;
    next_active_sel = active_sel;
    next_target_sel = target_sel;
    next_sw_cnt = sw_cnt;
    dev_tick = 1'b0;
    case (sw_state)
      scsu_pkg::SW_RUN:
      begin
        dev_tick = old_tick;
        if (want_sel != active_sel)
        begin
          next_target_sel = want_sel;
          next_sw_cnt = 2'h0;
          next_sw_state = scsu_pkg::SW_OLD;
        end
      end
      scsu_pkg::SW_OLD:
      begin
        if (old_tick)
          next_sw_cnt = sw_cnt + 2'h1;
        if (old_tick && sw_cnt == scsu_pkg::OLD_SRC_TICKS - 2'h1)
        begin
          next_sw_cnt = 2'h0;
          next_sw_state = scsu_pkg::SW_NEW;
        end
      end
      scsu_pkg::SW_NEW:
      begin
        if (new_tick)
          next_sw_cnt = sw_cnt + 2'h1;
        // Resuming on the next new tick gives three to four ticks of pause
        if (new_tick && sw_cnt == scsu_pkg::NEW_SRC_TICKS - 2'h1)
        begin
          next_active_sel = target_sel;
          next_sw_state = scsu_pkg::SW_RUN;
        end
      end
      default: next_sw_state = scsu_pkg::SW_RUN;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      sw_state <= scsu_pkg::SW_RUN;
      active_sel <= scsu_pkg::CSS_PRIMARY;
      target_sel <= scsu_pkg::CSS_PRIMARY;
      sw_cnt <= 2'h0;
    end
    else
    begin
      sw_state <= next_sw_state;
      active_sel <= next_active_sel;
      target_sel <= next_target_sel;
      sw_cnt <= next_sw_cnt;
    end
  end

  // Sleep instruction enters Idle or Sleep; a wake request leaves both
  always_comb
  begin
    next_sleep_mode = sleep_mode;
    next_idle_mode = idle_mode;
    if (WAKE_REQ)
    begin
      next_sleep_mode = 1'b0;
      next_idle_mode = 1'b0;
    end
    else if (SLEEP_REQ && !sleep_mode && !idle_mode)
    begin
      next_idle_mode = idle_on_sleep;
      next_sleep_mode = !idle_on_sleep;
    end
  end

  // Output registers; ticks appear one cycle after their cause
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      sleep_mode <= 1'b0;
      idle_mode <= 1'b0;
      DEV_CLK_TICK <= 1'b0;
      PLL_REF_TICK <= 1'b0;
      USB_FS_TICK <= 1'b0;
      USB_LS_TICK <= 1'b0;
      WDT_TICK <= 1'b0;
      FSCM_TICK <= 1'b0;
    end
    else
    begin
      sleep_mode <= next_sleep_mode;
      idle_mode <= next_idle_mode;
      // Sleep stops the device clock; Idle keeps peripherals running
      DEV_CLK_TICK <= dev_tick & ~sleep_mode;
      PLL_REF_TICK <= pll_ref & mode_pll;
      USB_FS_TICK <= pll_half & pll_active;
      USB_LS_TICK <= usb_ls;
      WDT_TICK <= SLOW_OSC_TICK;
      FSCM_TICK <= SLOW_OSC_TICK;
    end
  end

  assign SLEEP_MODE = sleep_mode;
  assign IDLE_MODE = idle_mode;
endmodule : scsu_top
`default_nettype wire

/* File: verif/scsu_osc_model.sv */
// Behavioural oscillators that feed tick pulses to the clock select unit
`timescale 1ns/1ns
`default_nettype none
module scsu_osc_model (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // One pulse per source period
  output logic pri_tick,
  output logic sec_tick,
  output logic fast_tick,
  output logic slow_tick,
  output logic pll_tick
);
  // Distinct periods so that each source shows by its tick count
  int n;
  always_ff @(posedge CLK)
  begin
    if (RESET)
      n <= 0;
    else
      n <= n + 1;
  end
  // Held quiet in reset so no stale tick leaks into the first cycle
  assign pri_tick = !RESET && (n % 4 == 3);
  assign sec_tick = !RESET && (n % 6 == 5);
  assign fast_tick = !RESET && (n % 3 == 2);
  assign slow_tick = !RESET && (n % 8 == 7);
  assign pll_tick = !RESET && (n % 2 == 1);
endmodule : scsu_osc_model
`default_nettype wire

/* File: verif/scsu_monitor.sv */
// Port checks for the system clock select unit
`timescale 1ns/1ns
`default_nettype none
module scsu_monitor (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Bus
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  // Ticks and power state
  input wire logic SLOW_OSC_TICK,
  input wire logic SLEEP_REQ,
  input wire logic WAKE_REQ,
  input wire logic DEV_CLK_TICK,
  input wire logic WDT_TICK,
  input wire logic FSCM_TICK,
  input wire logic SLEEP_MODE,
  input wire logic IDLE_MODE
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);
  ack_resp_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("Request not answered in the next cycle");
  ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("Ack longer than one cycle");
  ack_cause_a: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
    else $error("Ack without request");
  rdata_upper_a: assert property (WB_ACK_O |-> WB_DAT_O[31:10] == 22'h0)
    else $error("Unused read bits not zero");
  wdt_slow_a: assert property (WDT_TICK == ($past(SLOW_OSC_TICK) && !$past(RESET)))
    else $error("Watchdog tick not from slow oscillator");
  fscm_slow_a: assert property (FSCM_TICK == ($past(SLOW_OSC_TICK) && !$past(RESET)))
    else $error("Monitor tick not from slow oscillator");
  mode_excl_a: assert property (!(SLEEP_MODE && IDLE_MODE))
    else $error("Sleep and idle together");
  sleep_gate_a: assert property ($past(SLEEP_MODE) |-> !DEV_CLK_TICK)
    else $error("Device tick during sleep");
  wake_clear_a: assert property (WAKE_REQ |=> !SLEEP_MODE && !IDLE_MODE)
    else $error("Wake did not clear power state");
  sleep_enter_a: assert property (SLEEP_REQ && !WAKE_REQ && !SLEEP_MODE && !IDLE_MODE |=> SLEEP_MODE || IDLE_MODE)
    else $error("Sleep request ignored");
  mode_hold_a: assert property (SLEEP_MODE && !WAKE_REQ |=> SLEEP_MODE)
    else $error("Sleep left without wake");
endmodule : scsu_monitor
`default_nettype wire

/* File: verif/tb.sv */
// Self-checking bench for the system clock select unit
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
  $display("Error %s expected %0h seen %0h", n, e, g); end end
module tb;
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic ack, pri, sec, fast, slow, pll, dev, pref, fs, ls, wdt, slp, idl;
  logic sleep_req = 1'b0, wake_req = 1'b0;
  int bad_count = 0, comparisons = 0;
  int c[5];
  int dv[4] = '{6, 3, 2, 1};
  scsu_osc_model osc (.CLK(CLK), .RESET(RESET), .pri_tick(pri), .sec_tick(sec), .fast_tick(fast),
    .slow_tick(slow), .pll_tick(pll));
  scsu_top dut (.CLK(CLK), .RESET(RESET), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .PRI_OSC_TICK(pri),
    .SEC_OSC_TICK(sec), .FAST_OSC_TICK(fast), .SLOW_OSC_TICK(slow), .PLL_OUT_TICK(pll),
    .SLEEP_REQ(sleep_req), .WAKE_REQ(wake_req), .DEV_CLK_TICK(dev), .PLL_REF_TICK(pref),
    .USB_FS_TICK(fs), .USB_LS_TICK(ls), .WDT_TICK(wdt), .FSCM_TICK(), .SLEEP_MODE(slp), .IDLE_MODE(idl));
  initial forever #5 CLK = ~CLK;
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'hF, d};
    do @(posedge CLK); while (ack !== 1'b1 && ++n < 20);
    `CHK("ack", 1'b1, ack)
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask : bus
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(nm, e, q)
  endtask : rdchk
  // Counts device, reference, full-speed, low-speed and watchdog ticks
  task automatic count(input int w);
    c = '{default: 0};
    repeat (w)
    begin
      @(posedge CLK);
      c[0] += int'(dev === 1'b1);
      c[1] += int'(pref === 1'b1);
      c[2] += int'(fs === 1'b1);
      c[3] += int'(ls === 1'b1);
      c[4] += int'(wdt === 1'b1);
    end
  endtask : count
  task automatic pulse(input logic w);
    if (w)
      wake_req <= 1'b1;
    else
      sleep_req <= 1'b1;
    @(posedge CLK);
    {wake_req, sleep_req} <= 2'b00;
    @(posedge CLK);
  endtask : pulse
  task automatic t_reset;
    rdchk("control", 8'h00, 32'h64);
    rdchk("tuning", 8'h04, 32'h0);
    rdchk("timer1", 8'h08, 32'h0);
    rdchk("config", 8'h0C, 32'h374);
    rdchk("unmapped", 8'h10, 32'h0);
  endtask : t_reset
  task automatic t_start;
    int n;
    n = 0;
    do bus(1'b0, 8'h00, 32'h0); while (q[3] !== 1'b1 && ++n < 2000);
    rdchk("control", 8'h00, 32'h6C);
    count(120);
    `CHK("primary ticks", 30, c[0])
  endtask : t_start
  task automatic t_refuse;
    bus(1'b1, 8'h00, 32'h61);
    rdchk("control", 8'h00, 32'h6C);
    bus(1'b1, 8'h00, 32'h62);
    rdchk("control", 8'h00, 32'h6E);
    count(120);
    `CHK("reserved ticks", 30, c[0])
    bus(1'b1, 8'h00, 32'h60);
  endtask : t_refuse
  task automatic t_secondary;
    int p, s, n;
    {p, s, n} = 0;
    bus(1'b1, 8'h08, 32'h08);
    bus(1'b1, 8'h00, 32'h61);
    // A tick already in flight at the write may still show in the first two cycles
    do
    begin
      @(posedge CLK);
      p += int'(pri === 1'b1);
      s += int'(sec === 1'b1);
    end
    while ((dev !== 1'b1 || n < 2) && ++n < 300);
    `CHK("switch pause", 1'b1, p >= 2 && s >= 3)
    rdchk("timer1", 8'h08, 32'h48);
    rdchk("control", 8'h00, 32'h65);
    count(120);
    `CHK("secondary ticks", 20, c[0])
  endtask : t_secondary
  task automatic t_internal;
    for (int k = 0; k < 9; k++)
    begin
      bus(1'b1, 8'h04, (k == 8) ? 32'h80 : 32'h0);
      bus(1'b1, 8'h00, {24'h0, 1'b0, (k < 8) ? 3'(7 - k) : 3'h0, 4'h3});
      repeat (400) @(posedge CLK);
      count(768);
      `CHK("internal ticks", (k == 8) ? 1 : (k == 7) ? 96 : (256 >> k), c[0])
      `CHK("watchdog ticks", 96, c[4])
    end
    rdchk("control", 8'h00, 32'h07);
    rdchk("timer1", 8'h08, 32'h08);
  endtask : t_internal
  task automatic t_pll;
    bus(1'b1, 8'h00, 32'h60);
    bus(1'b1, 8'h04, 32'h40);
    for (int k = 3; k < 8; k++)
    begin
      bus(1'b1, 8'h0C, 32'h305 | (k << 4));
      repeat (100) @(posedge CLK);
      count(480);
      `CHK("pll reference", 120 / (8 - k), c[1])
    end
    // Every CPU rate keeps the 48 MHz full-speed clock; 24 MHz alone suits low speed
    // Odd steps use the external clock PLL mode, even steps the crystal PLL mode
    for (int k = 0; k < 4; k++)
    begin
      bus(1'b1, 8'h0C, ((k % 2) ? 32'h077 : 32'h075) | (k << 8));
      repeat (100) @(posedge CLK);
      count(480);
      `CHK("cpu ticks", 120 / dv[k], c[0])
      `CHK("usb full", 120, c[2])
      `CHK("usb low", 30 / dv[k], c[3])
    end
    // Internal block and plain external clock as primary; PLL paths fall quiet
    for (int k = 0; k < 2; k++)
    begin
      bus(1'b1, 8'h0C, (k == 1) ? 32'h376 : 32'h370);
      repeat (100) @(posedge CLK);
      count(480);
      `CHK("primary mode ticks", (k == 1) ? 120 : 80, c[0])
      `CHK("pll quiet", 0, c[1] + c[2])
      rdchk("control", 8'h00, 32'h6C);
    end
  endtask : t_pll
  task automatic t_sleep;
    bus(1'b1, 8'h00, 32'hE0);
    pulse(1'b0);
    `CHK("idle", 2'b01, {slp, idl})
    pulse(1'b1);
    `CHK("awake", 2'b00, {slp, idl})
    bus(1'b1, 8'h00, 32'h60);
    pulse(1'b0);
    `CHK("sleep", 2'b10, {slp, idl})
    count(60);
    `CHK("sleep ticks", 0, c[0])
    pulse(1'b1);
    `CHK("woken", 2'b00, {slp, idl})
  endtask : t_sleep
  task automatic tally_and_finish;
    $display("Mismatches %0d, comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (4) @(posedge CLK);
    RESET <= 1'b0;
    t_reset;
    t_start;
    t_refuse;
    t_secondary;
    t_internal;
    t_pll;
    t_sleep;
    // Second reset in mid-run, with a non-default source and frequency in place
    bus(1'b1, 8'h00, 32'h73);
    RESET <= 1'b1;
    repeat (4) @(posedge CLK);
    RESET <= 1'b0;
    t_reset;
    tally_and_finish;
  end
  // Whole run needs about 22000 cycles
  initial
  begin
    repeat (45000) @(posedge CLK);
    bad_count++;
    tally_and_finish;
  end
endmodule : tb
bind scsu_top scsu_monitor mon (.CLK(CLK), .RESET(RESET), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .SLOW_OSC_TICK(SLOW_OSC_TICK), .SLEEP_REQ(SLEEP_REQ),
  .WAKE_REQ(WAKE_REQ), .DEV_CLK_TICK(DEV_CLK_TICK), .WDT_TICK(WDT_TICK), .FSCM_TICK(FSCM_TICK),
  .SLEEP_MODE(SLEEP_MODE), .IDLE_MODE(IDLE_MODE));
`default_nettype wire
